// File: sep_map.vh
// constants for the serial eeprom protect, select and pause control
// Operation
// - block protect 00 none, 01 180h-1FFh, 10 100h-1FFh, 11 whole array
// - status write changes only the two block protect bits
// - status write cycle starts on chip select rising after a valid sequence
// - reset clears write enable latch, standby, serial output tri-stated
// - write enable latch clears after any array or status write
// - array accesses during an internal write are ignored
// - no sequence accepted until chip select is seen falling after reset
// - write protect low blocks all array and status writes
// - write protect low clears the latch; a running write still completes
// - protect high allows writes only with latch set, protected blocks stay
// - chip select high means standby once any running write ends
// - serial output is high impedance while deselected
// - programming starts only on chip select rising after whole bytes
// - serial input is captured on each rising serial clock edge
// - serial output changes only after a falling serial clock edge
// - pause lowered with clock high takes effect at the next clock low
// - while paused the sequence state is kept and clock and input ignored
// - pause resumes only when raised while the clock is low
// - lowering the pause input tri-states the serial output
// - busy flag reads one during an internal write, pollable any time
// - no array or status write completes unless the latch was set
`ifndef SEP_MAP_VH
`define SEP_MAP_VH
`define SEP_OPC_STATUS_WRITE 3'h1
`define SEP_OPC_WRITE 3'h2
`define SEP_OPC_READ 3'h3
`define SEP_OPC_LATCH_CLR 3'h4
`define SEP_OPC_STATUS_READ 3'h5
`define SEP_OPC_LATCH_SET 3'h6
`define SEP_BP_RST 2'h0
`define SEP_SR_BP_HI 3
`define SEP_SR_BP_LO 2
`define SEP_PROT_QUARTER 9'h180
`define SEP_PROT_HALF 9'h100
`define SEP_CLK_MHZ 24'd25
`define SEP_TWC_US 24'd5000
`define SEP_TWC_CYCLES (`SEP_TWC_US * `SEP_CLK_MHZ)
`define SEP_FIFO_DEPTH 8
`define SEP_FIFO_AW 3
`define SEP_WORD_W 17
`define SEP_PIN_RST 5'h13
`endif

// File: sep_protect_hold.v
// serial eeprom protect, select, pause control with write staging fifo
`timescale 1ns/1ps
`default_nettype none
`include "sep_map.vh"

module sep_fifo #(
	parameter W = 17,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire flush_i,
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [W-1:0] in_data_i,
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [W-1:0] out_data_o
);
	reg [W-1:0] mem [0:DEPTH-1];
	reg [AW:0] wr_ptr;
	reg [AW:0] rd_ptr;
	wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	wire empty = (wr_ptr == rd_ptr);
	wire push = in_valid_i & ~full;
	wire pop = out_ready_i & ~empty;

	assign in_ready_o = ~full;
	assign out_valid_o = ~empty;
	assign out_data_o = mem[rd_ptr[AW-1:0]];

	always @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data_i;
		end
	end

	always @(posedge clk_i) begin
		if (!rst_n_i || flush_i) begin
			wr_ptr <= {(AW+1){1'b0}};
			rd_ptr <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule

module sep_protect_hold #(
	parameter [23:0] TWC_CYCLES = `SEP_TWC_CYCLES
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire cs_n_i,
	input wire sck_i,
	input wire si_i,
	input wire hold_n_i,
	input wire wp_n_i,
	output reg so_o,
	output wire so_oe_o,
	input wire mem_wr_ready_i,
	output wire mem_wr_valid_o,
	output wire [8:0] mem_wr_addr_o,
	output wire [7:0] mem_wr_data_o,
	output wire write_busy_flag_o,
	output wire write_enable_latch_o,
	output wire [1:0] block_protect_o,
	output wire standby_o
);
	localparam [2:0] S_CMD = 3'h0;
	localparam [2:0] S_ADDR = 3'h1;
	localparam [2:0] S_WDATA = 3'h2;
	localparam [2:0] S_SDATA = 3'h3;
	localparam [2:0] S_DONE = 3'h4;
	localparam [2:0] S_SREAD = 3'h5;
	localparam [2:0] S_IGN = 3'h6;

	function prot_hit_f;
		input [1:0] bp;
		input [8:0] addr;
		begin
			case (bp)
				2'h0: prot_hit_f = 1'b0;
				2'h1: prot_hit_f = (addr >= `SEP_PROT_QUARTER);
				2'h2: prot_hit_f = (addr >= `SEP_PROT_HALF);
				default: prot_hit_f = 1'b1;
			endcase
		end
	endfunction

	// pin order: cs, sck, si, hold, wp
	reg [4:0] pin_s1;
	reg [4:0] pin_s2;
	reg cs_d;
	reg sck_d;
	reg hold_d;
	reg armed;
	reg paused;
	reg [2:0] state;
	reg [2:0] bitcnt;
	reg [2:0] obit;
	reg [2:0] opc;
	reg [6:0] shreg;
	reg [8:0] addr;
	reg [7:0] sbyte;
	reg prot_hit;
	reg ovf;
	reg write_enable_latch;
	reg [1:0] bp;
	reg busy;
	reg [23:0] tcnt;

	wire cs_n = pin_s2[4];
	wire sck = pin_s2[3];
	wire si = pin_s2[2];
	wire hold_n = pin_s2[1];
	wire wp_n = pin_s2[0];
	wire sck_rise = sck & ~sck_d;
	wire sck_fall = ~sck & sck_d;
	wire cs_rise = cs_n & ~cs_d;
	wire cs_fall = ~cs_n & cs_d;
	wire active = ~cs_n & armed & ~paused;
	wire bit_in = active & sck_rise;
	wire byte_done = bit_in & (bitcnt == 3'h7);
	wire [7:0] rx_byte = {shreg, si};
	wire [7:0] status = {4'h0, bp, write_enable_latch, busy};
	wire wr_ok = write_enable_latch & wp_n & ~busy;
	wire sr_commit = cs_rise & armed & (state == S_DONE) & (opc == `SEP_OPC_STATUS_WRITE)
		& wr_ok;
	wire f_in_ready;
	wire f_out_valid;
	wire [16:0] f_out_data;
	wire arr_commit = cs_rise & armed & (state == S_WDATA) & (bitcnt == 3'h0) & f_out_valid
		& wr_ok & ~prot_hit & ~ovf;
	wire commit = sr_commit | arr_commit;
	wire f_push = byte_done & (state == S_WDATA) & ~busy;
	wire f_flush = cs_rise & ~busy & ~commit;

	sep_fifo #(
		.W(`SEP_WORD_W),
		.DEPTH(`SEP_FIFO_DEPTH),
		.AW(`SEP_FIFO_AW)
	) u_fifo (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.flush_i(f_flush),
		.in_valid_i(f_push),
		.in_ready_o(f_in_ready),
		.in_data_i({addr, rx_byte}),
		.out_valid_o(f_out_valid),
		.out_ready_i(busy & mem_wr_ready_i),
		.out_data_o(f_out_data)
	);

	assign mem_wr_valid_o = busy & f_out_valid;
	assign mem_wr_addr_o = f_out_data[16:8];
	assign mem_wr_data_o = f_out_data[7:0];
	assign write_busy_flag_o = busy;
	assign write_enable_latch_o = write_enable_latch;
	assign block_protect_o = bp;
	assign standby_o = cs_n & ~busy;
	// output drive drops at once with deselect or pause
	assign so_oe_o = (state == S_SREAD) & ~cs_n & hold_n & ~paused;

	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			pin_s1 <= `SEP_PIN_RST;
			pin_s2 <= `SEP_PIN_RST;
			cs_d <= 1'b1;
			sck_d <= 1'b0;
			hold_d <= 1'b1;
		end else begin
			pin_s1 <= {cs_n_i, sck_i, si_i, hold_n_i, wp_n_i};
			pin_s2 <= pin_s1;
			cs_d <= cs_n;
			sck_d <= sck;
			hold_d <= hold_n;
		end
	end

	// selection and pause tracking
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			armed <= 1'b0;
			paused <= 1'b0;
		end else begin
			if (cs_fall) begin
				armed <= 1'b1;
			end
			if (cs_n) begin
				paused <= 1'b0;
			end else if (!paused) begin
				// a drop with the clock high waits until the clock is low
				if (!hold_n && !sck) begin
					paused <= 1'b1;
				end
			end else if (hold_n && !hold_d && !sck) begin
				paused <= 1'b0;
			end
		end
	end

	// serial sequence decode
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			state <= S_CMD;
			bitcnt <= 3'h0;
			obit <= 3'h0;
			opc <= 3'h0;
			shreg <= 7'h00;
			addr <= 9'h000;
			sbyte <= 8'h00;
			prot_hit <= 1'b0;
			ovf <= 1'b0;
			so_o <= 1'b0;
		end else if (cs_n) begin
			state <= S_CMD;
			bitcnt <= 3'h0;
			obit <= 3'h0;
			prot_hit <= 1'b0;
			ovf <= 1'b0;
		end else begin
			if (bit_in) begin
				shreg <= rx_byte[6:0];
				bitcnt <= bitcnt + 3'h1;
				if (state == S_DONE) begin
					state <= S_IGN;
				end
			end
			if (byte_done) begin
				case (state)
					S_CMD: begin
						opc <= rx_byte[2:0];
						addr[8] <= rx_byte[3];
						if (rx_byte[7:4] != 4'h0) begin
							state <= S_IGN;
						end else if (busy && rx_byte[2:0] != `SEP_OPC_STATUS_READ) begin
							state <= S_IGN;
						end else begin
							case (rx_byte[2:0])
								`SEP_OPC_WRITE: state <= S_ADDR;
								`SEP_OPC_STATUS_WRITE: state <= S_SDATA;
								`SEP_OPC_STATUS_READ: state <= S_SREAD;
								`SEP_OPC_LATCH_SET: state <= S_DONE;
								`SEP_OPC_LATCH_CLR: state <= S_DONE;
								default: state <= S_IGN;
							endcase
						end
					end
					S_ADDR: begin
						addr[7:0] <= rx_byte;
						state <= S_WDATA;
					end
					S_WDATA: begin
						// address wraps within the 16-byte page
						addr[3:0] <= addr[3:0] + 4'h1;
						if (prot_hit_f(bp, addr)) begin
							prot_hit <= 1'b1;
						end
						if (!f_in_ready) begin
							ovf <= 1'b1;
						end
					end
					S_SDATA: begin
						sbyte <= rx_byte;
						state <= S_DONE;
					end
					default: state <= state;
				endcase
			end
			if (active && sck_fall && state == S_SREAD) begin
				so_o <= status[~obit];
				obit <= obit + 3'h1;
			end
		end
	end

	// latch, protect bits and write cycle timer
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			write_enable_latch <= 1'b0;
			bp <= `SEP_BP_RST;
			busy <= 1'b0;
			tcnt <= 24'h000000;
		end else begin
			if (cs_rise && armed && state == S_DONE) begin
				if (opc == `SEP_OPC_LATCH_SET) begin
					write_enable_latch <= 1'b1;
				end else if (opc == `SEP_OPC_LATCH_CLR) begin
					write_enable_latch <= 1'b0;
				end
			end
			if (sr_commit) begin
				bp <= sbyte[`SEP_SR_BP_HI:`SEP_SR_BP_LO];
			end
			if (commit) begin
				busy <= 1'b1;
				tcnt <= TWC_CYCLES - 24'h000001;
				write_enable_latch <= 1'b0;
			end else if (busy) begin
				// running cycle ignores select and protect pins
				if (tcnt != 24'h000000) begin
					tcnt <= tcnt - 24'h000001;
				end else if (!f_out_valid) begin
					busy <= 1'b0;
				end
			end
			if (!wp_n) begin
				write_enable_latch <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// File: sep_chk_sva.sv
// port checker for the protect, select and pause block
`timescale 1ns/1ps
`default_nettype none
module sep_chk #(
	parameter [23:0] TWC_CYCLES = 24'h01e848
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic cs_n_i,
	input wire logic hold_n_i,
	input wire logic wp_n_i,
	input wire logic so_oe_o,
	input wire logic mem_wr_valid_o,
	input wire logic write_busy_flag_o,
	input wire logic write_enable_latch_o,
	input wire logic [1:0] block_protect_o
);
	int run;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	always @(posedge clk_i) run <= (!rst_n_i || !write_busy_flag_o) ? 0 : run + 1;
	a_reset_clears: assert property (disable iff (1'b0) !rst_n_i |=>
		!write_enable_latch_o && !write_busy_flag_o && !so_oe_o) else $error("reset");
	a_wp_clears: assert property (!wp_n_i [*4] |=> !write_enable_latch_o) else $error("wp");
	a_desel_hiz: assert property (cs_n_i [*4] |=> !so_oe_o) else $error("cs");
	a_pause_hiz: assert property (!hold_n_i [*4] |=> !so_oe_o) else $error("hold");
	a_commit_latch: assert property ($rose(write_busy_flag_o) |->
		$past(write_enable_latch_o) && !write_enable_latch_o) else $error("latch");
	a_commit_cs: assert property ($rose(write_busy_flag_o) |-> cs_n_i && $past(cs_n_i))
		else $error("start");
	a_busy_len: assert property ($fell(write_busy_flag_o) |-> run >= TWC_CYCLES - 1)
		else $error("twc");
	a_bp_commit: assert property ($changed(block_protect_o) |-> $rose(write_busy_flag_o))
		else $error("bp");
	a_mem_busy: assert property ($rose(mem_wr_valid_o) |-> $rose(write_busy_flag_o))
		else $error("mem");
	c_commit: cover property ($rose(write_busy_flag_o));
	c_read: cover property (so_oe_o);
	c_pop: cover property (mem_wr_valid_o);
endmodule
bind sep_protect_hold sep_chk #(.TWC_CYCLES(TWC_CYCLES)) sep_chk_inst (.*);
`default_nettype wire

// File: sep_host.sv
// spi host model driving the eeprom pins
`timescale 1ns/1ps
`default_nettype none
module sep_host (
	input wire logic clk_i,
	input wire logic so_i,
	output logic cs_n_o,
	output logic sck_o,
	output logic si_o,
	output logic hold_n_o
);
	initial {cs_n_o, sck_o, si_o, hold_n_o} = 4'hb;
	task automatic t(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// whole bytes msb first; pause with one stray clock before byte pz
	task automatic send(input logic [7:0] q[$], output logic [7:0] rx, input int pz = -1);
		t(1);
		cs_n_o = 1'b0;
		t(2);
		foreach (q[k]) begin
			if (k == pz) begin
				hold_n_o = 1'b0;
				t(4);
				sck_o = 1'b0;
				t(4);
				sck_o = 1'b1;
				t(4);
				sck_o = 1'b0;
				t(4);
				hold_n_o = 1'b1;
				t(4);
			end
			for (int i = 7; i >= 0; i--) begin
				{sck_o, si_o} = {1'b0, q[k][i]};
				t(4);
				sck_o = 1'b1;
				rx[i] = so_i;
				t(4);
			end
		end
		sck_o = 1'b0;
		t(2);
		{cs_n_o, si_o} = {1'b1, ~si_o};
		t(12);
	endtask
endmodule
`default_nettype wire

// File: sep_protect_hold_tb_top.sv
// bench for the protect, select and pause block
`timescale 1ns/1ps
`default_nettype none
module sep_protect_hold_tb_top;
	localparam logic [23:0] TWC = 24'h000190;
	logic clk_i = 1'b0, rst_n_i = 1'b0, wp_n_i = 1'b1, rdy = 1'b0, ok;
	logic [1:0] ebp = 2'h0;
	logic [7:0] rx;
	logic [7:0] q[$];
	logic [16:0] exq[$];
	int fails = 0, check_count = 0, seed = 50500;
	wire cs_n, sck, si, hold_n, so_q, oe, vld, busy, wlatch, sb;
	wire [8:0] wa;
	wire [7:0] wd;
	wire [1:0] bp;
	wire so = oe ? so_q : ~so_q;
	always #20 clk_i = ~clk_i;
	always @(negedge clk_i) rdy <= 1'($random(seed));
	sep_host sep_host_inst (.clk_i(clk_i), .so_i(so), .cs_n_o(cs_n), .sck_o(sck), .si_o(si),
		.hold_n_o(hold_n));
	sep_protect_hold #(.TWC_CYCLES(TWC)) sep_protect_hold_inst (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .hold_n_i(hold_n),
		.wp_n_i(wp_n_i), .so_o(so_q), .so_oe_o(oe), .mem_wr_ready_i(rdy), .mem_wr_valid_o(vld),
		.mem_wr_addr_o(wa), .mem_wr_data_o(wd), .write_busy_flag_o(busy),
		.write_enable_latch_o(wlatch), .block_protect_o(bp), .standby_o(sb));
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		if (fails == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic idle;
		repeat (2000) if (busy !== 1'b0) @(negedge clk_i);
		chk(busy, 1'b0);
	endtask
	always @(posedge clk_i) if ((vld & rdy) === 1'b1) chk({wa, wd}, exq.pop_front());
	task automatic ws(input logic [1:0] b, input logic en);
		ok = en && wp_n_i;
		sep_host_inst.send('{en ? 8'h06 : 8'h04}, rx);
		chk(wlatch, ok);
		sep_host_inst.send('{8'h01, {4'hf, b, 2'h3}}, rx);
		if (ok) ebp = b;
		chk({bp, sb, busy}, {ebp, !ok, ok});
		if (ok) sep_host_inst.send('{8'h06}, rx);
		sep_host_inst.send('{8'h05, 8'h00}, rx, b[0] ? 1 : -1);
		chk(rx, {4'h0, ebp, 1'b0, ok});
		idle;
	endtask
	task automatic wr(input logic [8:0] a, input int n, input logic en);
		q = '{{4'h0, a[8], 3'h2}, a[7:0]};
		ok = en && wp_n_i && n < 9;
		if (ebp == 2'h3 || ebp == 2'h2 && a[8] || ebp == 2'h1 && a[8:7] == 2'h3) ok = 1'b0;
		sep_host_inst.send('{en ? 8'h06 : 8'h04}, rx);
		for (int i = 0; i < n; i++) begin
			q.push_back(8'($random(seed)));
			if (ok) exq.push_back({a[8:4], a[3:0] + 4'(i), q[i + 2]});
		end
		sep_host_inst.send(q, rx);
		chk(busy, ok);
		idle;
		chk(17'(exq.size()), 17'h0);
	endtask
	initial begin
		repeat (6) @(negedge clk_i);
		chk({wlatch, busy, bp, oe, sb}, 6'h01);
		rst_n_i = 1'b1;
		repeat (4) @(negedge clk_i);
		ws(2'h1, 1'b0);
		for (int b = 0; b < 4; b++) ws(2'(b ^ 1), 1'b1);
		wr(9'h0ff, 8, 1'b1);
		wr(9'h100, 1, 1'b1);
		wr(9'h005, 9, 1'b1);
		wr(9'h005, 2, 1'b0);
		repeat (8) begin
			ws(2'($random(seed)), 1'b1);
			wr(9'($random(seed)), {$random(seed)} % 9 + 1, 1'b1);
		end
		ws(2'h0, 1'b1);
		wp_n_i = 1'b0;
		ws(2'h3, 1'b1);
		wr(9'h000, 1, 1'b1);
		give_verdict;
	end
	initial begin
		#3000000;
		fails++;
		give_verdict;
	end
endmodule
`default_nettype wire
